// File: shared/sgb_gpio_map.vh
// Register offsets, field masks, reset values for the six-bit GPIO bank
`ifndef SGB_GPIO_MAP_VH
`define SGB_GPIO_MAP_VH

`define SGB_ADDR_W            4
`define SGB_OFF_PIN_VALUE     4'h0
`define SGB_OFF_OUTPUT_LATCH  4'h1
`define SGB_OFF_DIRECTION     4'h2
`define SGB_OFF_ANALOG_SELECT 4'h3
`define SGB_OFF_PULLUP_EN     4'h4
`define SGB_OFF_OPEN_DRAIN    4'h5
`define SGB_OFF_SLEW_LIMIT    4'h6
`define SGB_OFF_IN_THRESHOLD  4'h7
`define SGB_OFF_LATCH_SET     4'h8
`define SGB_OFF_LATCH_CLEAR   4'h9

`define SGB_PIN_A3            3
`define SGB_MASK_ALL6         8'h3f
`define SGB_MASK_NO_A3        8'h37
`define SGB_MASK_A3           8'h08

`define SGB_RST_LATCH         8'h00
`define SGB_RST_DIRECTION     8'h37
`define SGB_RST_ANALOG        8'h37
`define SGB_RST_PULLUP        8'h00
`define SGB_RST_OPEN_DRAIN    8'h00
`define SGB_RST_SLEW          8'h37
`define SGB_RST_THRESHOLD     8'h3f

`endif

// File: rtl/sgb_pin_cell.v
// Combinational drive and pull-up decision for one GPIO pin
`timescale 1ns/1ps
`default_nettype none

module sgb_pin_cell (
    input  wire direction,
    input  wire latch_bit,
    input  wire open_drain_bit,
    input  wire periph_sel,
    input  wire periph_data,
    input  wire i2c_own,
    input  wire analog_out_en,
    input  wire input_only,
    input  wire pullup_bit,
    input  wire force_pullup,
    output wire pad_out,
    output wire pad_oe_n,
    output wire pullup_on
);
    wire src;
    wire drive_path;
    wire od_mode;
    wire drive_en;

    // Peripheral replaces the latch only when selected
    assign src        = periph_sel ? periph_data : latch_bit;   // see R8 see R9
    // Analog output wins over every digital driver
    assign drive_path = ~direction & ~analog_out_en & ~input_only; // see R2 see R3 see R10 see R12 see R14
    assign od_mode    = open_drain_bit | i2c_own;                // see R15 see R16
    // Open drain only ever sinks; a high is released
    assign drive_en   = drive_path & (~od_mode | ~src);          // see R15
    assign pad_out    = od_mode ? 1'b0 : src;                    // see R2
    assign pad_oe_n   = ~drive_en;
    assign pullup_on  = force_pullup |
                        (pullup_bit & (~drive_path | (od_mode & src))); // see R20 see R22 see R24
endmodule

`default_nettype wire

// File: rtl/sgb_gpio_bank.v
// Six-bit bidirectional GPIO bank with byte-wide register port
//
// Function
// R1 - Six pins, byte-wide port registers
// R2 - Direction one disables driver, zero drives latch
// R3 - Pin three input-only, direction reads one
// R4 - Port read gives pins, write goes latch
// R5 - Latch write equals port write; reads latch
// R6 - Writes read pins, modify bits, store latch
// R7 - Latch keeps last write, feeds pins
// R8 - After reset pins output latch data; the code resets direction to all ones, so every pin starts as an input
// R9 - Enabled peripheral blocks latch output, reads work
// R10 - Analog output forces digital driver off
// R11 - Analog select disables input, reads zero
// R12 - Analog select never gates digital output
// R13 - Analog select bits reset to analog
// R14 - Direction controls drivers on analog pins
// R15 - Open-drain bit gives sink-only drive
// R16 - I2C ownership forces open-drain drive
// R17 - Slew bit selects limited or fast
// R18 - Threshold bit picks Schmitt or TTL
// R19 - Software changes threshold with peripherals off
// R20 - Each pin has switchable weak pull-up
// R21 - Pin three is master clear, disableable
// R22 - Pin three pull-up on if enable or bit
// R23 - Pin three reads one while clear enabled
// R24 - Pull-up off for outputs except open-drain high; the code keeps it on where analog output turns the driver off
// R25 - Bits seven and six read zero
// R26 - Writes act on drivers at completing edge
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sgb_gpio_map.vh"

module sgb_gpio_bank #(
    parameter PINS = 6
) (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire [`SGB_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [7:0]             reg_rdata,
    input  wire [PINS-1:0]        pad_in_schmitt,
    input  wire [PINS-1:0]        pad_in_ttl,
    output reg  [PINS-1:0]        pad_out,
    output reg  [PINS-1:0]        pad_oe_n,
    output reg  [PINS-1:0]        pad_pullup_on,
    output reg  [PINS-1:0]        pad_slew_limited,
    output reg  [PINS-1:0]        pad_ttl_select,
    output reg  [PINS-1:0]        pin_level,
    input  wire [PINS-1:0]        periph_sel,
    input  wire [PINS-1:0]        periph_data,
    input  wire [PINS-1:0]        i2c_own,
    input  wire [PINS-1:0]        analog_out_en,
    input  wire                   master_clear_enable,
    output reg                    master_clear_req
);

    // Software-visible state
    reg  [7:0]      latch_q;
    reg  [7:0]      latch_d;
    reg  [7:0]      direction_q;
    reg  [7:0]      direction_d;
    reg  [7:0]      analog_q;
    reg  [7:0]      analog_d;
    reg  [7:0]      pullup_q;
    reg  [7:0]      pullup_d;
    reg  [7:0]      open_drain_q;
    reg  [7:0]      open_drain_d;
    reg  [7:0]      slew_q;
    reg  [7:0]      slew_d;
    reg  [7:0]      threshold_q;
    reg  [7:0]      threshold_d;

    // Sampled input levels
    reg  [PINS-1:0] level_q;
    reg  [PINS-1:0] level_d;
    reg  [PINS-1:0] raw_level;
    reg  [7:0]      rdata_d;

    // Pin cell decisions, computed from next-state values
    wire [PINS-1:0] cell_out;
    wire [PINS-1:0] cell_oe_n;
    wire [PINS-1:0] cell_pullup;

    wire            wr_pin_value;
    wire            wr_latch;
    wire            wr_set;
    wire            wr_clear;
    wire            wr_port;
    wire            wr_direction;
    wire            wr_analog;
    wire            wr_pullup;
    wire            wr_open_drain;
    wire            wr_slew;
    wire            wr_threshold;
    wire [7:0]      port_view;

    // Keeps unimplemented bits at zero on every store and read
    function [7:0] impl;
        input [7:0] value;
        input [7:0] mask;
        begin
            impl = value & mask;                                 // see R25
        end
    endfunction

    // Byte register write decode
    function hit;
        input [`SGB_ADDR_W-1:0] addr;
        input [`SGB_ADDR_W-1:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    assign wr_pin_value = reg_wr & hit(reg_addr, `SGB_OFF_PIN_VALUE);
    assign wr_latch     = reg_wr & hit(reg_addr, `SGB_OFF_OUTPUT_LATCH);
    assign wr_set       = reg_wr & hit(reg_addr, `SGB_OFF_LATCH_SET);
    assign wr_clear     = reg_wr & hit(reg_addr, `SGB_OFF_LATCH_CLEAR);
    assign wr_direction = reg_wr & hit(reg_addr, `SGB_OFF_DIRECTION);
    assign wr_analog    = reg_wr & hit(reg_addr, `SGB_OFF_ANALOG_SELECT);
    assign wr_pullup    = reg_wr & hit(reg_addr, `SGB_OFF_PULLUP_EN);
    assign wr_open_drain = reg_wr & hit(reg_addr, `SGB_OFF_OPEN_DRAIN);
    assign wr_slew      = reg_wr & hit(reg_addr, `SGB_OFF_SLEW_LIMIT);
    assign wr_threshold = reg_wr & hit(reg_addr, `SGB_OFF_IN_THRESHOLD);
    assign wr_port      = wr_pin_value | wr_latch;               // see R5
    assign port_view    = {{(8-PINS){1'b0}}, level_q};

    // Input sampling: threshold choice, analog gate, master clear override
    always @* begin
        raw_level = (pad_in_ttl & threshold_q[PINS-1:0]) |
                    (pad_in_schmitt & ~threshold_q[PINS-1:0]);   // see R18
        level_d   = raw_level & ~analog_q[PINS-1:0];             // see R11 see R12
        if (master_clear_enable) begin
            level_d[`SGB_PIN_A3] = 1'b1;                         // see R23
        end
    end

    // Latch next value; bit ops are read-modify-write on pin levels
    always @* begin
        latch_d = latch_q;
        if (wr_port) begin
            latch_d = impl(reg_wdata, `SGB_MASK_NO_A3);          // see R4 see R5 see R7
        end else if (wr_set) begin
            // Pins read low by analog select or load get written back low
            latch_d = impl(port_view | reg_wdata, `SGB_MASK_NO_A3);  // see R6
        end else if (wr_clear) begin
            latch_d = impl(port_view & ~reg_wdata, `SGB_MASK_NO_A3); // see R6
        end
    end

    always @* begin
        direction_d = direction_q;
        if (wr_direction) begin
            direction_d = impl(reg_wdata, `SGB_MASK_NO_A3) | `SGB_MASK_A3; // see R3
        end
    end

    always @* begin
        analog_d = analog_q;
        if (wr_analog) begin
            analog_d = impl(reg_wdata, `SGB_MASK_NO_A3);
        end
    end

    always @* begin
        pullup_d = pullup_q;
        if (wr_pullup) begin
            pullup_d = impl(reg_wdata, `SGB_MASK_ALL6);          // see R20
        end
    end

    always @* begin
        open_drain_d = open_drain_q;
        if (wr_open_drain) begin
            open_drain_d = impl(reg_wdata, `SGB_MASK_NO_A3);     // see R15
        end
    end

    always @* begin
        slew_d = slew_q;
        if (wr_slew) begin
            slew_d = impl(reg_wdata, `SGB_MASK_NO_A3);           // see R17
        end
    end

    always @* begin
        threshold_d = threshold_q;
        // A change while peripherals run may glitch their inputs
        if (wr_threshold) begin
            threshold_d = impl(reg_wdata, `SGB_MASK_ALL6);       // see R18
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `SGB_OFF_PIN_VALUE: begin
                    rdata_d = port_view;                         // see R4
                end
                `SGB_OFF_OUTPUT_LATCH: begin
                    rdata_d = impl(latch_q, `SGB_MASK_NO_A3);    // see R5
                end
                `SGB_OFF_DIRECTION: begin
                    rdata_d = impl(direction_q, `SGB_MASK_NO_A3) | `SGB_MASK_A3; // see R3
                end
                `SGB_OFF_ANALOG_SELECT: begin
                    rdata_d = impl(analog_q, `SGB_MASK_NO_A3);
                end
                `SGB_OFF_PULLUP_EN: begin
                    rdata_d = impl(pullup_q, `SGB_MASK_ALL6);
                end
                `SGB_OFF_OPEN_DRAIN: begin
                    rdata_d = impl(open_drain_q, `SGB_MASK_NO_A3);
                end
                `SGB_OFF_SLEW_LIMIT: begin
                    rdata_d = impl(slew_q, `SGB_MASK_NO_A3);
                end
                `SGB_OFF_IN_THRESHOLD: begin
                    rdata_d = impl(threshold_q, `SGB_MASK_ALL6);
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // Control registers, one flop group each
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= `SGB_RST_LATCH;
        end else begin
            latch_q <= latch_d;                                  // see R26
        end
    end

    // Pin three direction is pinned to input even through reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            direction_q <= `SGB_RST_DIRECTION | `SGB_MASK_A3;
        end else begin
            direction_q <= direction_d;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_q <= `SGB_RST_ANALOG;                         // see R13
        end else begin
            analog_q <= analog_d;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pullup_q <= `SGB_RST_PULLUP;
        end else begin
            pullup_q <= pullup_d;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            open_drain_q <= `SGB_RST_OPEN_DRAIN;
        end else begin
            open_drain_q <= open_drain_d;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slew_q <= `SGB_RST_SLEW;
        end else begin
            slew_q <= slew_d;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            threshold_q <= `SGB_RST_THRESHOLD;
        end else begin
            threshold_q <= threshold_d;
        end
    end

    // Input sample and read data
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q   <= {PINS{1'b0}};
            reg_rdata <= 8'h00;
            pin_level <= {PINS{1'b0}};
        end else begin
            level_q   <= level_d;
            reg_rdata <= rdata_d;
            pin_level <= level_d;                                // see R18
        end
    end

    // One cell per pin, fed from next-state so drivers move with the write edge
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
            sgb_pin_cell u_cell (
                .direction      (direction_d[gi]),
                .latch_bit      (latch_d[gi]),
                .open_drain_bit (open_drain_d[gi]),
                .periph_sel     (periph_sel[gi]),
                .periph_data    (periph_data[gi]),
                .i2c_own        (i2c_own[gi]),
                .analog_out_en  (analog_out_en[gi]),
                .input_only     (gi == `SGB_PIN_A3),
                .pullup_bit     (pullup_d[gi]),
                .force_pullup   ((gi == `SGB_PIN_A3) & master_clear_enable),
                .pad_out        (cell_out[gi]),
                .pad_oe_n       (cell_oe_n[gi]),
                .pullup_on      (cell_pullup[gi])
            );
        end
    endgenerate

    // Registered pad controls; reset releases all drivers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out          <= {PINS{1'b0}};
            pad_oe_n         <= {PINS{1'b1}};
            pad_pullup_on    <= {PINS{1'b0}};
            pad_slew_limited <= {PINS{1'b0}};
            pad_ttl_select   <= {PINS{1'b0}};
            master_clear_req <= 1'b0;
        end else begin
            pad_out          <= cell_out;                        // see R1 see R26
            pad_oe_n         <= cell_oe_n;
            pad_pullup_on    <= cell_pullup;
            pad_slew_limited <= slew_d[PINS-1:0];                // see R17
            pad_ttl_select   <= threshold_d[PINS-1:0];           // see R18
            // Master clear is active low on the pin
            master_clear_req <= master_clear_enable &
                                ~raw_level[`SGB_PIN_A3];         // see R21
        end
    end

endmodule

`default_nettype wire

// File: test/sgb_gpio_bank_asserts.sv
// Port-level assertions for the GPIO bank
`timescale 1ns/1ps
`default_nettype none
`include "sgb_gpio_map.vh"
module sgb_gpio_bank_asserts #(
    parameter PINS = 6
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic [`SGB_ADDR_W-1:0] reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    input wire logic [PINS-1:0]        pad_in_schmitt,
    input wire logic [PINS-1:0]        pad_in_ttl,
    input wire logic [PINS-1:0]        pad_out,
    input wire logic [PINS-1:0]        pad_oe_n,
    input wire logic [PINS-1:0]        pad_pullup_on,
    input wire logic [PINS-1:0]        pad_slew_limited,
    input wire logic [PINS-1:0]        pad_ttl_select,
    input wire logic [PINS-1:0]        pin_level,
    input wire logic [PINS-1:0]        periph_sel,
    input wire logic [PINS-1:0]        periph_data,
    input wire logic [PINS-1:0]        i2c_own,
    input wire logic [PINS-1:0]        analog_out_en,
    input wire logic                   master_clear_enable,
    input wire logic                   master_clear_req
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_a3_never_driven: assert property (pad_oe_n[3]) else $error("pin three driven");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
    chk_analog_hiz: assert property ((~pad_oe_n & $past(analog_out_en)) == '0) else $error("analog pin driven");
    chk_i2c_sink: assert property ((pad_out & $past(i2c_own)) == '0) else $error("i2c pin sources");
    chk_pullup_driven: assert property ((pad_pullup_on & ~pad_oe_n) == '0) else $error("pullup on driven pin");
    chk_clear_pullup: assert property ($past(rst_n) && $past(master_clear_enable) |-> pad_pullup_on[3])
        else $error("pin three pullup off");
    chk_port_read: assert property (reg_rd && reg_addr == `SGB_OFF_PIN_VALUE |=>
        reg_rdata == {2'b00, $past(pin_level)}) else $error("port read wrong");
    chk_slew_write: assert property (reg_wr && reg_addr == `SGB_OFF_SLEW_LIMIT |=>
        ($past(reg_wdata) & 8'h37) == {2'b00, pad_slew_limited}) else $error("slew not applied");
    cov_port_read: cover property (reg_rd && reg_addr == `SGB_OFF_PIN_VALUE);
    cov_latch_set: cover property (reg_wr && reg_addr == `SGB_OFF_LATCH_SET);
    cov_master_clear: cover property (master_clear_req);
endmodule
`default_nettype wire

// File: test/sgb_pin_world.sv
// Circuitry on the pins: drivers, pull-ups, external sources
`timescale 1ns/1ps
`default_nettype none
module sgb_pin_world (
    input  wire logic       clk,
    input  wire logic [5:0] pad_out,
    input  wire logic [5:0] pad_oe_n,
    input  wire logic [5:0] pad_pullup_on,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    input  wire logic [5:0] ext_mid,
    output logic      [5:0] pad_in_schmitt,
    output logic      [5:0] pad_in_ttl
);
    logic       float_q = 1'b0;
    logic [5:0] lvl;
    logic [5:0] mid;
    // Undriven lines without pull-up wander so no stale level reads as valid
    always @(posedge clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!pad_oe_n[i]) lvl[i] = pad_out[i];
            else if (ext_en[i]) lvl[i] = ext_val[i];
            else lvl[i] = pad_pullup_on[i] | float_q;
        end
    end
    // A mid-rail source on a released pin reads high on TTL, low on Schmitt
    assign mid = ext_mid & ext_en & pad_oe_n;
    assign pad_in_schmitt = lvl & ~mid;
    assign pad_in_ttl = lvl | mid;
endmodule
`default_nettype wire

// File: test/sgb_gpio_bank_bench.sv
// Directed bench for the six-bit GPIO bank
`timescale 1ns/1ps
`default_nettype none
`include "sgb_gpio_map.vh"
module sgb_gpio_bank_bench;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       mce = 1'b1;
    logic [5:0] ext_mid = 6'h00;
    logic [5:0] sel = 6'h00, pdat = 6'h00, i2c = 6'h00, aout = 6'h00, ext_en = 6'h00, ext_val = 6'h00;
    logic [7:0] rdata;
    logic [5:0] sch, ttl, pout, oen, pup, slew, tsel, plvl;
    logic       mreq;
    int         error_cnt = 0;
    int         tests_run = 0;
    always #12.5 clk = ~clk;
    sgb_gpio_bank #(.PINS(6)) sgb_gpio_bank_inst (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .pad_in_schmitt(sch),
        .pad_in_ttl(ttl), .pad_out(pout), .pad_oe_n(oen), .pad_pullup_on(pup), .pad_slew_limited(slew),
        .pad_ttl_select(tsel), .pin_level(plvl), .periph_sel(sel), .periph_data(pdat), .i2c_own(i2c),
        .analog_out_en(aout), .master_clear_enable(mce), .master_clear_req(mreq));
    sgb_pin_world sgb_pin_world_inst (.clk(clk), .pad_out(pout), .pad_oe_n(oen), .pad_pullup_on(pup),
        .ext_en(ext_en), .ext_val(ext_val), .ext_mid(ext_mid), .pad_in_schmitt(sch), .pad_in_ttl(ttl));
    task automatic final_report();
        $display("Compares %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp(rdata, exp);
    endtask
    // Bounded wait; a stuck request ends the run
    task automatic wait_req(input logic e);
        int n;
        n = 0;
        while (mreq !== e && n < 10) begin
            tick(1);
            n++;
        end
        cmp({7'h00, mreq}, {7'h00, e});
        if (mreq !== e) final_report();
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        cmp({2'b00, oen}, 8'h3f);
        cmp({2'b00, pup}, 8'h08);
        cmp({2'b00, tsel}, 8'h3f);
        rd_reg(`SGB_OFF_DIRECTION, 8'h3f);
        rd_reg(`SGB_OFF_ANALOG_SELECT, 8'h37);
        rd_reg(`SGB_OFF_OUTPUT_LATCH, 8'h00);
        rd_reg(`SGB_OFF_PULLUP_EN, 8'h00);
        rd_reg(`SGB_OFF_OPEN_DRAIN, 8'h00);
        rd_reg(`SGB_OFF_SLEW_LIMIT, 8'h37);
        rd_reg(`SGB_OFF_IN_THRESHOLD, 8'h3f);
        rd_reg(4'hc, 8'h00);
        rd_reg(`SGB_OFF_PIN_VALUE, 8'h08);
        wr_reg(`SGB_OFF_ANALOG_SELECT, 8'h00);
        wr_reg(`SGB_OFF_OUTPUT_LATCH, 8'hff);
        wr_reg(4'hc, 8'h00);
        rd_reg(`SGB_OFF_OUTPUT_LATCH, 8'h37);
        wr_reg(`SGB_OFF_DIRECTION, 8'h00);
        cmp({2'b00, oen}, 8'h08);
        cmp({2'b00, pout}, 8'h37);
        rd_reg(`SGB_OFF_DIRECTION, 8'h08);
        wr_reg(`SGB_OFF_PULLUP_EN, 8'h3f);
        cmp({2'b00, pup}, 8'h08);
        rd_reg(`SGB_OFF_PIN_VALUE, 8'h3f);
        wr_reg(`SGB_OFF_PIN_VALUE, 8'h05);
        rd_reg(`SGB_OFF_OUTPUT_LATCH, 8'h05);
        wr_reg(`SGB_OFF_LATCH_SET, 8'h30);
        rd_reg(`SGB_OFF_OUTPUT_LATCH, 8'h35);
        // Analog pin still drives but reads low, so a port update loses it
        wr_reg(`SGB_OFF_ANALOG_SELECT, 8'h01);
        cmp({2'b00, pout}, 8'h35);
        cmp({2'b00, oen}, 8'h08);
        rd_reg(`SGB_OFF_PIN_VALUE, 8'h3c);
        wr_reg(`SGB_OFF_LATCH_CLEAR, 8'h20);
        rd_reg(`SGB_OFF_OUTPUT_LATCH, 8'h14);
        wr_reg(`SGB_OFF_OPEN_DRAIN, 8'h3f);
        cmp({2'b00, oen}, 8'h1c);
        cmp({2'b00, pout}, 8'h00);
        cmp({2'b00, pup}, 8'h1c);
        wr_reg(`SGB_OFF_OPEN_DRAIN, 8'h00);
        wr_reg(`SGB_OFF_OUTPUT_LATCH, 8'h16);
        @(posedge clk);
        i2c <= 6'h02;
        sel <= 6'h20;
        pdat <= 6'h20;
        aout <= 6'h01;
        tick(2);
        cmp({2'b00, oen}, 8'h0b);
        cmp({2'b00, pout}, 8'h34);
        cmp({2'b00, pup & 6'h3e}, 8'h0a);
        rd_reg(`SGB_OFF_PIN_VALUE, 8'h3e);
        cmp({2'b00, plvl}, 8'h3e);
        @(posedge clk);
        i2c <= 6'h00;
        sel <= 6'h00;
        aout <= 6'h00;
        wr_reg(`SGB_OFF_SLEW_LIMIT, 8'h05);
        cmp({2'b00, slew}, 8'h05);
        wr_reg(`SGB_OFF_IN_THRESHOLD, 8'h00);
        cmp({2'b00, tsel}, 8'h00);
        @(posedge clk);
        ext_en <= 6'h08;
        ext_val <= 6'h00;
        wait_req(1'b1);
        rd_reg(`SGB_OFF_PIN_VALUE, 8'h1e);
        @(posedge clk);
        mce <= 1'b0;
        wait_req(1'b0);
        rd_reg(`SGB_OFF_PIN_VALUE, 8'h16);
        cmp({2'b00, plvl}, 8'h16);
        // Pin three at mid-rail: Schmitt reads low, TTL reads high
        @(posedge clk);
        ext_mid <= 6'h08;
        rd_reg(`SGB_OFF_PIN_VALUE, 8'h16);
        wr_reg(`SGB_OFF_IN_THRESHOLD, 8'h08);
        cmp({2'b00, tsel}, 8'h08);
        rd_reg(`SGB_OFF_PIN_VALUE, 8'h1e);
        cmp({2'b00, plvl}, 8'h1e);
        cmp({2'b00, pup}, 8'h08);
        wr_reg(`SGB_OFF_PULLUP_EN, 8'h00);
        cmp({2'b00, pup}, 8'h00);
        final_report();
    end
endmodule
bind sgb_gpio_bank sgb_gpio_bank_asserts #(.PINS(PINS)) sgb_gpio_bank_asserts_inst (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pad_in_schmitt(pad_in_schmitt), .pad_in_ttl(pad_in_ttl), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_on(pad_pullup_on), .pad_slew_limited(pad_slew_limited), .pad_ttl_select(pad_ttl_select),
    .pin_level(pin_level), .periph_sel(periph_sel), .periph_data(periph_data), .i2c_own(i2c_own),
    .analog_out_en(analog_out_en), .master_clear_enable(master_clear_enable),
    .master_clear_req(master_clear_req));
`default_nettype wire
